// >>> hdl/lintmc_core.sv
// lintmc_core: mode state machine, dominant time-out, wake detection, reset delay
// assumes pins and comparator levels are asynchronous; one 50 MHz clock
`timescale 1ns/1ns

// Function
// - enable high gives normal mode: transmit, receive and regulator active
// - in normal mode low transmit input drives bus dominant, high leaves recessive
// - in normal mode receive output follows the bus level
// - transmit low beyond 6 ms forces the driver recessive
// - transmit high over 10 us after time-out re-arms the driver
// - enable falling with transmit high selects silent, regulator stays on
// - enable falling with transmit low selects sleep, regulator off
// - sleep drives reset output and receive output low
// - sleep entry never disturbs the bus, even with late transmit fall
// - silent and sleep drop termination until bus below prewake threshold
// - fall, dominant beyond wake filter, then rise is a remote wake-up
// - wake in silent gives fail-safe, receive low; enable high gives normal
// - wake in sleep gives fail-safe, regulator on, receive low
// - enable high in sleep gives fail-safe, then normal after reset delay
// - power-up enters fail-safe with regulator on, reset low 4 ms
// - fail-safe waits for enable high, then goes to normal
// - battery below 3.7 V in silent or sleep returns in fail-safe
// - low reset output in normal, select or silent places the device in fail-safe at once
// - regulator undervoltage in normal or silent: reset low, fail-safe
// - reset held low 4 ms after vcc nominal, no mode change meanwhile
// - battery below 5 V disables transmission
module lintmc_core
  import lintmc_pkg::*;
#(
  parameter int DOM_TIMEOUT_CYC = DOM_CYC,
  parameter int RESET_DELAY_CYC = RESET_CYC
) (
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  input  wire logic   i_txd,
  input  wire logic   i_en,
  input  wire logic   i_bus,
  input  wire logic   i_prewake,
  input  wire logic   i_bat_ok,
  input  wire logic   i_bat_present,
  input  wire logic   i_vcc_ok,
  output logic        o_rxd,
  output logic        o_bus_out,
  output logic        o_bus_oe_n,
  output logic        o_reset_out_n,
  output logic        o_reg_on,
  output logic        o_term_on,
  output lintmc_mode_t o_mode
);

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 20'h00001;
  endfunction

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = n[CNT_W-1:0];
  endfunction

  // ==========================================================
  // input synchronisers
  lintmc_pins_t pins_raw;
  lintmc_pins_t sync1_q;
  lintmc_pins_t pins_q;

  assign pins_raw = '{txd: i_txd, en: i_en, bus: i_bus, prewake: i_prewake,
                      bat_ok: i_bat_ok, bat_present: i_bat_present, vcc_ok: i_vcc_ok};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= PINS_RST;
      pins_q  <= PINS_RST;
    end else begin
      sync1_q <= pins_raw;
      pins_q  <= sync1_q;
    end
  end

  // ==========================================================
  // state
  lintmc_mode_t     mode_q,   mode_d;
  logic [CNT_W-1:0] dom_q,    dom_d;
  logic [CNT_W-1:0] rec_q,    rec_d;
  logic             lock_q,   lock_d;
  logic [CNT_W-1:0] rcnt_q,   rcnt_d;
  logic             rst_q,    rst_d;
  logic [CNT_W-1:0] sel_q,    sel_d;
  logic [CNT_W-1:0] wcnt_q,   wcnt_d;
  logic             bus_p_q,  bus_p_d;
  logic             wake_q,   wake_d;
  logic             term_q,   term_d;
  logic             rxd_q,    rxd_d;
  logic             oe_n_q,   oe_n_d;
  logic             reg_q,    reg_d;
  logic             wake_ev;
  logic             quiet;

  always_comb begin
    mode_d  = mode_q;
    dom_d   = dom_q;
    rec_d   = rec_q;
    lock_d  = lock_q;
    rcnt_d  = rcnt_q;
    sel_d   = sel_q;
    wcnt_d  = wcnt_q;
    bus_p_d = pins_q.bus;
    wake_d  = wake_q;
    wake_ev = 1'b0;
    quiet   = (mode_q == M_SILENT) || (mode_q == M_SLEEP);

    // dominant time-out and re-arm
    if (!pins_q.txd) begin
      dom_d = sat_inc(dom_q);
      rec_d = CNT_ZERO;
      if (dom_q >= cyc(DOM_TIMEOUT_CYC)) begin
        lock_d = 1'b1;
      end
    end else begin
      dom_d = CNT_ZERO;
      rec_d = sat_inc(rec_q);
      if (rec_q >= cyc(RECOVER_CYC)) begin
        lock_d = 1'b0;
      end
    end

    // reset delay after regulator reaches nominal
    if (pins_q.vcc_ok && reg_q && mode_q != M_SLEEP) begin
      rcnt_d = sat_inc(rcnt_q);
    end else begin
      rcnt_d = CNT_ZERO;
    end
    // wake filter, runs only with the receiver back on
    if (quiet && term_q) begin
      if (bus_p_q && !pins_q.bus) begin
        wcnt_d = CNT_ZERO;
      end else if (!pins_q.bus) begin
        wcnt_d = sat_inc(wcnt_q);
      end else if (!bus_p_q && pins_q.bus) begin
        wake_ev = (wcnt_q >= cyc(WAKE_CYC));
        wcnt_d  = CNT_ZERO;
      end
    end else begin
      wcnt_d = CNT_ZERO;
    end

    // mode transitions
    unique case (mode_q)
      M_UNPOWERED: begin
        if (pins_q.bat_present) begin
          mode_d = M_FAILSAFE;
        end
      end
      M_FAILSAFE: begin
        if (rst_q && pins_q.en) begin
          mode_d = M_NORMAL;
          wake_d = 1'b0;
        end
      end
      M_NORMAL: begin
        if (!rst_q) begin
          mode_d = M_FAILSAFE;
        end else if (!pins_q.en) begin
          mode_d = M_SELECT;
          sel_d  = CNT_ZERO;
        end
      end
      M_SELECT: begin
        sel_d = sat_inc(sel_q);
        if (!rst_q) begin
          mode_d = M_FAILSAFE;
        end else if (pins_q.en) begin
          mode_d = M_NORMAL;
        end else if (sel_q >= cyc(SELECT_CYC)) begin
          mode_d = pins_q.txd ? M_SILENT : M_SLEEP;
        end
      end
      M_SILENT: begin
        if (!rst_q) begin
          mode_d = M_FAILSAFE;
        end else if (wake_ev) begin
          mode_d = M_FAILSAFE;
          wake_d = 1'b1;
        end else if (pins_q.en) begin
          mode_d = M_NORMAL;
        end
      end
      M_SLEEP: begin
        if (wake_ev) begin
          mode_d = M_FAILSAFE;
          wake_d = 1'b1;
        end else if (pins_q.en) begin
          mode_d = M_FAILSAFE;
        end
      end
      default: mode_d = M_FAILSAFE;
    endcase

    if (!pins_q.bat_present) begin
      mode_d = M_UNPOWERED;
      wake_d = 1'b0;
    end

    // termination and receiver in low-power modes
    if (mode_d == M_SILENT || mode_d == M_SLEEP) begin
      term_d = quiet && (term_q || pins_q.prewake);
    end else begin
      term_d = (mode_d != M_UNPOWERED);
    end

    reg_d = (mode_d != M_SLEEP) && (mode_d != M_UNPOWERED);

    // reset drops on the same edge the regulator is switched off
    rst_d = (rcnt_q >= cyc(RESET_DELAY_CYC)) && pins_q.vcc_ok && reg_q
            && reg_d;

    // driver: only normal mode, armed, supply good
    oe_n_d = !((mode_d == M_NORMAL) && !pins_q.txd && !lock_d
               && pins_q.bat_ok && rst_d);

    unique case (mode_d)
      M_NORMAL:   rxd_d = pins_q.bus;
      M_FAILSAFE: rxd_d = !wake_d;
      M_SLEEP:    rxd_d = 1'b0;
      M_UNPOWERED: rxd_d = 1'b1;
      default:    rxd_d = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q  <= M_UNPOWERED;
      dom_q   <= CNT_ZERO;
      rec_q   <= CNT_ZERO;
      lock_q  <= 1'b0;
      rcnt_q  <= CNT_ZERO;
      rst_q   <= RSTOUT_RST;
      sel_q   <= CNT_ZERO;
      wcnt_q  <= CNT_ZERO;
      bus_p_q <= 1'b1;
      wake_q  <= 1'b0;
      term_q  <= 1'b0;
      rxd_q   <= RXD_RST;
      oe_n_q  <= 1'b1;
      reg_q   <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      dom_q   <= dom_d;
      rec_q   <= rec_d;
      lock_q  <= lock_d;
      rcnt_q  <= rcnt_d;
      rst_q   <= rst_d;
      sel_q   <= sel_d;
      wcnt_q  <= wcnt_d;
      bus_p_q <= bus_p_d;
      wake_q  <= wake_d;
      term_q  <= term_d;
      rxd_q   <= rxd_d;
      oe_n_q  <= oe_n_d;
      reg_q   <= reg_d;
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bus_out <= 1'b0;
    end else begin
      o_bus_out <= 1'b0;  // open drain, only ever pulls low
    end
  end

  assign o_rxd         = rxd_q;
  assign o_bus_oe_n    = oe_n_q;
  assign o_reset_out_n = rst_q;
  assign o_reg_on      = reg_q;
  assign o_term_on     = term_q;
  assign o_mode        = mode_q;

  // ==========================================================
  // assertions
  property p_normal_en;
    @(posedge i_clk) disable iff (!i_reset_n)
      (mode_q == M_FAILSAFE && rst_q && pins_q.en && pins_q.bat_present)
      |=> (mode_q == M_NORMAL && reg_q);
  endproperty
  a_normal_en: assert property (p_normal_en) else $error("no normal mode on enable");

  property p_drive_only_normal;
    @(posedge i_clk) disable iff (!i_reset_n)
      !oe_n_q |-> (mode_q == M_NORMAL && !lock_q && rst_q && $past(pins_q.bat_ok));
  endproperty
  a_drive_only_normal: assert property (p_drive_only_normal) else $error("bad drive");

  property p_rxd_follows;
    @(posedge i_clk) disable iff (!i_reset_n)
      (mode_q == M_NORMAL) |-> (rxd_q == $past(pins_q.bus));
  endproperty
  a_rxd_follows: assert property (p_rxd_follows) else $error("rxd not bus");

  property p_dom_lock;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!pins_q.txd && dom_q >= cyc(DOM_TIMEOUT_CYC)) |=> (lock_q && oe_n_q);
  endproperty
  a_dom_lock: assert property (p_dom_lock) else $error("time-out missed");

  property p_rearm;
    @(posedge i_clk) disable iff (!i_reset_n)
      (lock_q && pins_q.txd && rec_q >= cyc(RECOVER_CYC)) |=> !lock_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("driver not re-armed");

  property p_select;
    @(posedge i_clk) disable iff (!i_reset_n)
      (mode_q == M_SELECT && rst_q && !pins_q.en && pins_q.bat_present
       && sel_q >= cyc(SELECT_CYC))
      |=> (mode_q == ($past(pins_q.txd) ? M_SILENT : M_SLEEP));
  endproperty
  a_select: assert property (p_select) else $error("wrong mode selected");

  property p_sleep_low;
    @(posedge i_clk) disable iff (!i_reset_n)
      (mode_q == M_SLEEP) |-> (!rxd_q && !rst_q && !reg_q && oe_n_q);
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("sleep outputs wrong");

  property p_wake;
    @(posedge i_clk) disable iff (!i_reset_n)
      (wake_ev && quiet && pins_q.bat_present && (rst_q || mode_q == M_SLEEP))
      |=> (mode_q == M_FAILSAFE && !rxd_q && reg_q);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not indicated");

  property p_reset_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(rst_q) |-> ($past(rcnt_q) >= cyc(RESET_DELAY_CYC));
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early");

  property p_rst_failsafe;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!rst_q && pins_q.bat_present && (mode_q == M_NORMAL || mode_q == M_SILENT))
      |=> (mode_q == M_FAILSAFE);
  endproperty
  a_rst_failsafe: assert property (p_rst_failsafe) else $error("no fail-safe on reset");

  property p_undervolt;
    @(posedge i_clk) disable iff (!i_reset_n)
      !pins_q.bat_ok |=> oe_n_q;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("driving at low supply");

  c_sleep_wake:  cover property (@(posedge i_clk) mode_q == M_SLEEP && wake_ev);
  c_silent:      cover property (@(posedge i_clk) mode_q == M_SELECT ##1 mode_q == M_SILENT);
  c_dom_lock:    cover property (@(posedge i_clk) $rose(lock_q));
  c_normal_up:   cover property (@(posedge i_clk) $rose(mode_q == M_NORMAL));

endmodule

// >>> hdl/lintmc_pkg.sv
// lintmc_pkg: constants, types and timing counts for the LIN transceiver mode control
// assumes a single 50 MHz clock; analog comparators arrive as digital levels
package lintmc_pkg;

  // ==========================================================
  // clock and printed times
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_DOM_MS      = 6;     // dominant time-out
  localparam int T_RECOVER_US  = 10;    // txd high to re-arm driver
  localparam int T_RESET_MS    = 4;     // reset delay after vcc nominal
  localparam int T_SELECT_NS   = 3200;  // mode select window after enable fall
  localparam int T_WAKE_US     = 30;    // wake filter time, plain default

  // ==========================================================
  // cycle counts: least times round up, windows round down
  localparam int DOM_CYC     = (T_DOM_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC   = (T_RESET_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC    = (T_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_RAW  = T_SELECT_NS / CLK_PERIOD_NS;
  localparam int SELECT_CYC  = (SELECT_RAW < 1) ? 1 : SELECT_RAW;

  // ==========================================================
  // counter width and reset values
  localparam int                CNT_W      = 20;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 20'h00000;
  localparam logic              RXD_RST    = 1'h1;
  localparam logic              RSTOUT_RST = 1'h0;

  // ==========================================================
  // synchronised pin and comparator levels
  typedef struct packed {
    logic txd;          // transmit input, low = dominant
    logic en;           // mode enable input
    logic bus;          // bus receiver, high = recessive
    logic prewake;      // bus below prewake_threshold
    logic bat_ok;       // battery_supply above 5 V
    logic bat_present;  // battery_supply above 3.7 V
    logic vcc_ok;       // regulator output at nominal
  } lintmc_pins_t;

  localparam lintmc_pins_t PINS_RST = 7'h50;  // txd and bus idle high, rest low

  typedef enum logic [2:0] {
    M_UNPOWERED,
    M_FAILSAFE,
    M_NORMAL,
    M_SELECT,
    M_SILENT,
    M_SLEEP
  } lintmc_mode_t;

endpackage

// >>> verif/lintmc_mcu_model.sv
// lintmc_mcu_model: controller side driving the transmit and enable pins
// assumes bench requests change 2 ns after the rising clock edge
`timescale 1ns/1ns

module lintmc_mcu_model
  import lintmc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_want_en,
  input  wire logic       i_want_txd,
  input  wire logic [7:0] i_lag,
  output logic            o_en,
  output logic            o_txd
);
  int         hold_cnt;
  logic       want_en_s;
  logic       want_txd_s;
  logic [7:0] lag_s;

  // ==========================================================
  // pin sequencing
  initial begin
    o_en = 1'b0;
    o_txd = 1'b1;
    hold_cnt = 0;
  end

  always @(posedge i_clk) begin
    // requests taken at the edge, before the bench moves them
    want_en_s  = i_want_en;
    want_txd_s = i_want_txd;
    lag_s      = i_lag;
    #2;
    if (o_en && !want_en_s) begin
      o_en = 1'b0;
      hold_cnt = SELECT_CYC + 4 + int'(lag_s);  // txd frozen over select window
    end else if (want_en_s) begin
      o_en = 1'b1;
    end
    if (hold_cnt > 0) begin
      if (hold_cnt == SELECT_CYC + 4 && !want_txd_s) begin
        o_txd = 1'b0;  // txd may fall late after enable
      end
      hold_cnt--;
    end else begin
      o_txd = want_txd_s;  // low asks for dominant, high held to re-arm
    end
  end
endmodule

// >>> verif/tb_lintmc_core.sv
// tb_lintmc_core: self-checking bench for the mode control core
// assumes shortened time-out and reset delay parameters, one 50 MHz clock
`timescale 1ns/1ns

module tb_lintmc_core;
  import lintmc_pkg::*;
  localparam int         DOM_T = 200;
  localparam int         RST_T = 50;
  localparam logic [7:0] MODE  = 8'hE0;
  localparam logic [7:0] RX    = 8'h10;
  localparam logic [7:0] OE    = 8'h08;
  localparam logic [7:0] RS    = 8'h04;
  localparam logic [7:0] RG    = 8'h02;
  localparam logic [7:0] TM    = 8'h01;

  typedef struct {
    string      nm;
    logic [7:0] m;
    logic [7:0] v;
  } lintmc_note_t;

  logic         i_clk, i_reset_n, want_en, want_txd, ext_rec, prewake;
  logic         bat_ok, bat_pres, vcc_ok, txd, en;
  logic [7:0]   lag;
  logic [31:0]  r;
  wire logic    bus_lvl;
  wire logic    o_rxd, o_bus_out, o_bus_oe_n, o_reset_out_n, o_reg_on, o_term_on;
  lintmc_mode_t o_mode;
  wire logic [7:0] obs = {o_mode, o_rxd, o_bus_oe_n, o_reset_out_n, o_reg_on, o_term_on};
  lintmc_note_t q[$];
  lintmc_note_t n;
  event         chk_ev;
  int           error_cnt = 0;
  int           cmp_count = 0;
  int           cyc_cnt = 0;

  // bus wire: pulled dominant by the driver or by a remote node
  assign bus_lvl = (o_bus_oe_n | o_bus_out) & ext_rec;

  lintmc_mcu_model mcu_u (.i_clk(i_clk), .i_want_en(want_en), .i_want_txd(want_txd),
                          .i_lag(lag), .o_en(en), .o_txd(txd));

  lintmc_core #(.DOM_TIMEOUT_CYC(DOM_T), .RESET_DELAY_CYC(RST_T)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_txd(txd), .i_en(en), .i_bus(bus_lvl),
    .i_prewake(prewake), .i_bat_ok(bat_ok), .i_bat_present(bat_pres), .i_vcc_ok(vcc_ok),
    .o_rxd(o_rxd), .o_bus_out(o_bus_out), .o_bus_oe_n(o_bus_oe_n),
    .o_reset_out_n(o_reset_out_n), .o_reg_on(o_reg_on), .o_term_on(o_term_on),
    .o_mode(o_mode));

  // ==========================================================
  // checking
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk(input string nm, input logic [7:0] m, input logic [7:0] v);
    q.push_back('{nm, m, v & m});
    -> chk_ev;
  endtask

  always @(chk_ev) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      check(obs & n.m, n.v, n.nm);
    end
  end

  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, time limit and helpers
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #2;
  endtask

  task automatic wait_rst();
    int k;
    k = 0;
    while (o_reset_out_n !== 1'b1 && k < 500) begin
      cyc(1);
      k++;
    end
    cyc(4);
  endtask

  task automatic wake();
    prewake = 1'b1;
    cyc(6);
    chk("term", TM, 8'hFF);
    ext_rec = 1'b0;
    cyc(WAKE_CYC + 20);
    ext_rec = 1'b1;
    prewake = 1'b0;
    cyc(8);
    chk("mode", MODE, {M_FAILSAFE, 5'h00});
    chk("rxd", RX, 8'h00);
  endtask

  task automatic sleep_in(input logic [7:0] l);
    lag = l;
    want_txd = 1'b0;
    want_en = 1'b0;
    cyc(4);
    chk("oe_n", OE, 8'hFF);
    cyc(80);
    chk("oe_n", OE, 8'hFF);
    cyc(SELECT_CYC);
    chk("mode", MODE, {M_SLEEP, 5'h00});
    chk("rxd_rst", RX | RS, 8'h00);
    chk("reg_term", RG | TM, 8'h00);
    vcc_ok = 1'b0;
    want_txd = 1'b1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    i_reset_n = 1'b0;
    want_en = 1'b0;
    want_txd = 1'b1;
    lag = 8'h00;
    ext_rec = 1'b1;
    prewake = 1'b0;
    bat_ok = 1'b1;
    bat_pres = 1'b1;
    vcc_ok = 1'b1;
    r = $urandom(32'h10842915);
    cyc(5);
    i_reset_n = 1'b1;
    want_en = 1'b1;
    cyc(20);
    chk("mode", MODE, {M_FAILSAFE, 5'h00});
    chk("reg_rst", RG | RS, 8'h02);
    wait_rst();
    chk("mode", MODE, {M_NORMAL, 5'h00});
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      want_txd = r[0];
      ext_rec = r[1];
      cyc(9);
      chk("oe_n", OE, {8{want_txd}});
      chk("rxd", RX, {8{want_txd & ext_rec}});
    end
    ext_rec = 1'b1;
    want_txd = 1'b0;
    cyc(DOM_T + 12);
    chk("oe_n", OE, 8'hFF);
    want_txd = 1'b1;
    cyc(100);
    want_txd = 1'b0;
    cyc(8);
    chk("oe_n", OE, 8'hFF);
    want_txd = 1'b1;
    cyc(RECOVER_CYC + 12);
    want_txd = 1'b0;
    cyc(8);
    chk("oe_n", OE, 8'h00);
    bat_ok = 1'b0;
    cyc(6);
    chk("oe_n", OE, 8'hFF);
    bat_ok = 1'b1;
    want_txd = 1'b1;
    cyc(8);
    want_en = 1'b0;
    cyc(SELECT_CYC + 12);
    chk("mode", MODE, {M_SILENT, 5'h00});
    chk("reg_term", RG | TM, 8'h02);
    want_txd = 1'b0;
    cyc(8);
    chk("oe_n", OE, 8'hFF);
    want_txd = 1'b1;
    wake();
    want_en = 1'b1;
    cyc(6);
    chk("mode", MODE, {M_NORMAL, 5'h00});
    chk("rxd", RX, 8'hFF);
    sleep_in(8'h03);
    wake();
    chk("reg", RG, 8'hFF);
    vcc_ok = 1'b1;
    wait_rst();
    want_en = 1'b1;
    cyc(6);
    chk("mode", MODE, {M_NORMAL, 5'h00});
    sleep_in(8'h00);
    want_en = 1'b1;
    cyc(6);
    chk("mode", MODE, {M_FAILSAFE, 5'h00});
    chk("reset", RS, 8'h00);
    vcc_ok = 1'b1;
    wait_rst();
    chk("mode", MODE, {M_NORMAL, 5'h00});
    vcc_ok = 1'b0;
    cyc(6);
    chk("mode", MODE, {M_FAILSAFE, 5'h00});
    chk("reset", RS, 8'h00);
    vcc_ok = 1'b1;
    wait_rst();
    chk("mode", MODE, {M_NORMAL, 5'h00});
    want_en = 1'b0;
    cyc(40);
    want_en = 1'b1;
    cyc(8);
    chk("mode", MODE, {M_NORMAL, 5'h00});
    want_en = 1'b0;
    cyc(SELECT_CYC + 12);
    chk("mode", MODE, {M_SILENT, 5'h00});
    want_en = 1'b1;
    cyc(6);
    chk("mode", MODE, {M_NORMAL, 5'h00});
    want_en = 1'b0;
    cyc(SELECT_CYC + 12);
    bat_pres = 1'b0;
    cyc(6);
    chk("mode", MODE, {M_UNPOWERED, 5'h00});
    bat_pres = 1'b1;
    cyc(8);
    chk("mode", MODE, {M_FAILSAFE, 5'h00});
    cyc(2);
    conclude();
  end
endmodule
